// ### logic/dsa_pkg.sv
// Purpose: shared constants and types for the operand ALU slice
// Assumes: 16-bit working registers, 40-bit accumulators
// Notes:   register offsets are byte addresses on the bus
package dsa_pkg;
  // ****************************
  // Register map
  // ****************************
  localparam logic [11:0] ADDR_CMD   = 12'h000;
  localparam logic [11:0] ADDR_STAT  = 12'h004;
  localparam logic [11:0] ADDR_ACCA0 = 12'h008;
  localparam logic [11:0] ADDR_ACCA1 = 12'h00c;
  localparam logic [11:0] ADDR_ACCB0 = 12'h010;
  localparam logic [11:0] ADDR_ACCB1 = 12'h014;
  localparam logic [11:0] ADDR_WBASE = 12'h040;
  localparam logic [11:0] ADDR_MBASE = 12'h100;
  localparam int          STAT_ACCF  = 8;

  // ****************************
  // Reset values and limits
  // ****************************
  localparam logic [15:0] W_RST   = 16'h0000;
  localparam logic [39:0] ACC_RST = 40'h00_0000_0000;
  localparam logic [39:0] ACC_MAX = 40'h7f_ffff_ffff;
  localparam logic [39:0] ACC_MIN = 40'h80_0000_0000;
  localparam logic [15:0] DIV_Z_Q = 16'hffff;

  // ****************************
  // Working register roles
  // ****************************
  localparam int         NUM_W  = 16;
  localparam logic [3:0] W_IMPL = 4'h0;
  localparam logic [3:0] W_REM  = 4'h1;
  localparam logic [3:0] W_PFD  = 4'h4;
  localparam logic [3:0] W_XLO  = 4'h8;
  localparam logic [3:0] W_XHI  = 4'h9;
  localparam logic [3:0] W_YLO  = 4'ha;
  localparam logic [3:0] W_YHI  = 4'hb;
  localparam logic [3:0] W_IDX  = 4'hc;
  localparam logic [2:0] NUM_PAIRS = 3'h6;
  localparam logic [7:0] MAC_PAIRS [0:5] = '{8'h45, 8'h46, 8'h47, 8'h56, 8'h57, 8'h67};
  localparam logic [2:0] PF_PLAIN = 3'h0;
  localparam logic [2:0] PF_LAST  = 3'h7;

  // ****************************
  // Types
  // ****************************
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADD_WITH_CARRY_F = 5'h01, OP_ADD_WITH_CARRY_L10 = 5'h02, OP_ADD_WITH_CARRY_RR = 5'h03,
    OP_ADD_WITH_CARRY_L5 = 5'h04, OP_AND_F = 5'h05, OP_AND_L10 = 5'h06, OP_AND_RR = 5'h07,
    OP_AND_L5 = 5'h08, OP_ASR_F = 5'h09, OP_ASR_W = 5'h0a, OP_ASR_REG = 5'h0b,
    OP_ASR_LIT = 5'h0c, OP_BIT_CLEAR_OP_F = 5'h0d, OP_BIT_CLEAR_OP_W = 5'h0e, OP_ACC_ADD = 5'h0f,
    OP_MAC = 5'h10, OP_SQR = 5'h11, OP_DIV = 5'h12
  } dsa_op_t;

  typedef enum logic [2:0] {
    ALU_ADD_WITH_CARRY = 3'b000, ALU_AND = 3'b001, ALU_ASR1 = 3'b010,
    ALU_ASRN = 3'b011, ALU_BIT_CLEAR_OP = 3'b100
  } dsa_alu_t;

  typedef struct packed {
    logic [1:0] rsv;
    logic       acc_sel;
    logic       to_default_work_reg;
    logic       byte_mode;
    logic [9:0] lit;
    logic [3:0] dst;
    logic [3:0] src;
    logic [3:0] base;
    dsa_op_t    op;
  } dsa_cmd_t;

  typedef struct packed {
    logic dc;
    logic n;
    logic ov;
    logic z;
    logic c;
  } dsa_flags_t;

  typedef struct packed {
    logic sb;
    logic sa;
    logic ob;
    logic oa;
  } dsa_accf_t;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic        upd;
    logic        hi;
    logic [15:0] ptr;
  } dsa_pf_t;
endpackage

// ### logic/dsa_agu.sv
// Purpose: prefetch address and pointer update for one data space
// Assumes: mode[3] picks the high pointer, mode[2:0] the modifier
// Notes:   purely combinational
`timescale 1ns/1ps
module dsa_agu
  import dsa_pkg::*;
(
  input  logic [3:0]  mode,
  input  logic [15:0] ptr_lo,
  input  logic [15:0] ptr_hi,
  input  logic [15:0] idx,
  output dsa_pf_t     pf
);
  logic [15:0] base;
  logic [2:0]  dec;

  always_comb begin
    base    = mode[3] ? ptr_hi : ptr_lo;
    dec     = mode[2:0] - 3'h3;
    pf.hi   = mode[3];
    pf.en   = 1'b1;
    pf.upd  = 1'b0;
    pf.addr = base;
    pf.ptr  = base;
    unique case (mode[2:0])
      PF_PLAIN: pf.upd = 1'b0;
      3'h1, 3'h2, 3'h3: begin
        pf.upd = 1'b1;
        pf.ptr = base + {13'h0000, mode[1:0], 1'b0};
      end
      3'h4, 3'h5, 3'h6: begin
        pf.upd = 1'b1;
        pf.ptr = base - {12'h000, dec, 1'b0};
      end
      PF_LAST: begin
        pf.en   = mode[3];
        pf.addr = ptr_hi + idx;
      end
    endcase
  end
endmodule

// ### logic/dsa_alu.sv
// Purpose: 16-bit add with carry, and, shifts and bit clear
// Assumes: caller selects operands and destination
// Notes:   byte mode keeps the upper byte of the first operand, except for ALU_ASRN and ALU_BIT_CLEAR_OP
`timescale 1ns/1ps
module dsa_alu
  import dsa_pkg::*;
(
  input  dsa_alu_t    fn,
  input  logic        byte_mode,
  input  logic [15:0] a,
  input  logic [15:0] b,
  input  logic [4:0]  cnt,
  input  dsa_flags_t  fin,
  output logic [15:0] res,
  output dsa_flags_t  fout
);
  logic [16:0] sum;
  logic [4:0]  nib;
  logic [8:0]  bsum;
  logic        bm;
  logic        ma;
  logic        mb;
  logic        mr;
  logic        zero;

  always_comb begin
    sum  = {1'b0, a} + {1'b0, b} + {16'h0000, fin.c};
    nib  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, fin.c};
    bsum = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, fin.c};
    bm   = byte_mode && fn != ALU_ASRN && fn != ALU_BIT_CLEAR_OP;
    fout = fin;
    unique case (fn)
      ALU_ADD_WITH_CARRY: begin
        res     = sum[15:0];
        fout.c  = bm ? bsum[8] : sum[16];
        fout.dc = nib[4];
      end
      ALU_AND:  res = a & b;
      ALU_ASR1: begin
        res     = bm ? {a[15:8], a[7], a[7:1]} : {a[15], a[15:1]};
        fout.c  = a[0];
        fout.ov = 1'b0;
      end
      ALU_ASRN: res = 16'($signed(a) >>> cnt);
      ALU_BIT_CLEAR_OP: res = a & ~(16'h0001 << cnt[3:0]);
      default:  res = a;
    endcase
    if (bm) begin
      res[15:8] = a[15:8];
    end
    ma   = bm ? a[7] : a[15];
    mb   = bm ? b[7] : b[15];
    mr   = bm ? res[7] : res[15];
    zero = bm ? (res[7:0] == 8'h00) : (res == 16'h0000);
    if (fn != ALU_BIT_CLEAR_OP) begin
      fout.n = mr;
      fout.z = (fn == ALU_ADD_WITH_CARRY) ? (fin.z & zero) : zero;
    end
    if (fn == ALU_ADD_WITH_CARRY) begin
      fout.ov = (ma == mb) && (mr != ma);
    end
  end
endmodule

// ### logic/dsa_alu_core.sv
// Purpose: operand ALU slice with working registers, accumulators and data memory
// Assumes: one AHB-Lite master, single word transfers
// Notes:   writes take no wait state, reads take one
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module dsa_alu_core
  import dsa_pkg::*;
#(
  parameter int MEM_DEPTH = 64
)
(
  input  logic        SYS_CLK,
  input  logic        NRST,
  input  logic        HSEL,
  input  logic [31:0] HADDR,
  input  logic [1:0]  HTRANS,
  input  logic        HWRITE,
  input  logic [2:0]  HSIZE,
  input  logic [31:0] HWDATA,
  input  logic        HREADY,
  output logic [31:0] HRDATA,
  output logic        HREADYOUT,
  output logic        HRESP
);
  localparam int MW = $clog2(MEM_DEPTH);

  // ****************************
  // Declarations
  // ****************************
  logic [11:0]   adr_reg;
  logic [11:0]   adr_next;
  logic          ok_reg;
  logic          ok_next;
  logic          wr_reg;
  logic          wr_next;
  logic          rd_reg;
  logic          rd_next;
  logic          rdy_reg;
  logic          rdy_next;
  logic [31:0]   rdata_reg;
  logic [31:0]   rdata_next;
  logic          resp_reg;
  logic [31:0]   rd_mux;
  logic          take;
  logic          w_hit;
  logic          m_hit;
  logic [3:0]    w_idx;
  logic [MW-1:0] m_idx;
  logic [15:0]   w_reg     [NUM_W];
  logic [15:0]   w_next    [NUM_W];
  logic [15:0]   mem_reg   [MEM_DEPTH];
  logic [15:0]   mem_next  [MEM_DEPTH];
  logic [39:0]   acc_a_reg;
  logic [39:0]   acc_a_next;
  logic [39:0]   acc_b_reg;
  logic [39:0]   acc_b_next;
  dsa_flags_t    flags_reg;
  dsa_flags_t    flags_next;
  dsa_accf_t     accf_reg;
  dsa_accf_t     accf_next;
  dsa_cmd_t      cmd;
  logic          exec;
  logic [MW-1:0] f_idx;
  logic [9:0]    medium_literal;
  dsa_alu_t      alu_fn;
  logic [15:0]   alu_a;
  logic [15:0]   alu_b;
  logic [4:0]    alu_cnt;
  logic [15:0]   alu_r;
  dsa_flags_t    alu_fl;
  logic          alu_go;
  logic          to_mem;
  logic [3:0]    dst_idx;
  logic [7:0]    pair;
  logic [3:0]    ma;
  logic [3:0]    mb;
  logic          acc_go;
  logic [31:0]   prod;
  logic [39:0]   ext;
  logic [39:0]   acc_add;
  logic [41:0]   acc_res;
  logic [15:0]   quo;
  logic [15:0]   rem;
  dsa_pf_t       xpf;
  dsa_pf_t       ypf;

  // ****************************
  // Bus slave
  // ****************************
  assign take  = HSEL && HREADY && HTRANS[1];
  assign w_hit = ok_reg && adr_reg[11:6] == ADDR_WBASE[11:6];
  assign w_idx = adr_reg[5:2];
  assign m_hit = ok_reg && adr_reg[11:8] == ADDR_MBASE[11:8]
                 && {26'h0000000, adr_reg[7:2]} < MEM_DEPTH;
  assign m_idx = adr_reg[MW+1:2];

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (ok_reg && adr_reg == ADDR_STAT) begin
      rd_mux = {20'h00000, accf_reg, 3'h0, flags_reg};
    end else if (ok_reg && adr_reg == ADDR_ACCA0) begin
      rd_mux = acc_a_reg[31:0];
    end else if (ok_reg && adr_reg == ADDR_ACCA1) begin
      rd_mux = {24'h000000, acc_a_reg[39:32]};
    end else if (ok_reg && adr_reg == ADDR_ACCB0) begin
      rd_mux = acc_b_reg[31:0];
    end else if (ok_reg && adr_reg == ADDR_ACCB1) begin
      rd_mux = {24'h000000, acc_b_reg[39:32]};
    end else if (w_hit) begin
      rd_mux = {16'h0000, w_reg[w_idx]};
    end else if (m_hit) begin
      rd_mux = {16'h0000, mem_reg[m_idx]};
    end
  end

  always_comb begin
    adr_next   = take ? HADDR[11:0] : adr_reg;
    ok_next    = take ? (HADDR[31:12] == 20'h00000) : ok_reg;
    wr_next    = take && HWRITE;
    rd_next    = take && !HWRITE;
    rdy_next   = !(take && !HWRITE);
    rdata_next = rd_reg ? rd_mux : rdata_reg;
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      adr_reg   <= 12'h000;
      ok_reg    <= 1'b0;
      wr_reg    <= 1'b0;
      rd_reg    <= 1'b0;
      rdy_reg   <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      resp_reg  <= 1'b0;
    end else begin
      adr_reg   <= adr_next;
      ok_reg    <= ok_next;
      wr_reg    <= wr_next;
      rd_reg    <= rd_next;
      rdy_reg   <= rdy_next;
      rdata_reg <= rdata_next;
      resp_reg  <= 1'b0;
    end
  end

  assign HRDATA    = rdata_reg;
  assign HREADYOUT = rdy_reg;
  assign HRESP     = resp_reg;

  // ****************************
  // Operand select
  // ****************************
  assign cmd   = dsa_cmd_t'(HWDATA);
  assign exec  = wr_reg && ok_reg && adr_reg == ADDR_CMD;
  assign f_idx = cmd.lit[MW-1:0];
  assign medium_literal = cmd.byte_mode ? {2'b00, cmd.lit[7:0]} : cmd.lit;

  always_comb begin
    alu_a   = w_reg[cmd.base];
    alu_b   = w_reg[cmd.src];
    alu_cnt = {1'b0, cmd.lit[3:0]};
    alu_go  = 1'b1;
    to_mem  = 1'b0;
    dst_idx = cmd.dst;
    unique case (cmd.op)
      OP_ADD_WITH_CARRY_F, OP_AND_F, OP_ASR_F, OP_BIT_CLEAR_OP_F: begin
        alu_a   = mem_reg[f_idx];
        alu_b   = w_reg[W_IMPL];
        to_mem  = !cmd.to_default_work_reg || cmd.op == OP_BIT_CLEAR_OP_F;
        dst_idx = W_IMPL;
      end
      OP_ADD_WITH_CARRY_L10, OP_AND_L10: begin
        alu_a = w_reg[cmd.dst];
        alu_b = {6'h00, medium_literal};
      end
      OP_ADD_WITH_CARRY_L5, OP_AND_L5, OP_ASR_LIT: begin
        alu_b   = {11'h000, cmd.lit[4:0]};
        alu_cnt = cmd.lit[4:0];
      end
      OP_ASR_W, OP_BIT_CLEAR_OP_W: begin
        alu_a = w_reg[cmd.src];
        if (cmd.op == OP_BIT_CLEAR_OP_W) begin
          dst_idx = cmd.src;
        end
      end
      OP_ADD_WITH_CARRY_RR, OP_AND_RR: alu_b = w_reg[cmd.src];
      OP_ASR_REG: alu_cnt = w_reg[cmd.src][4:0];
      default: alu_go = 1'b0;
    endcase
    unique case (cmd.op)
      OP_ADD_WITH_CARRY_F, OP_ADD_WITH_CARRY_L10, OP_ADD_WITH_CARRY_RR, OP_ADD_WITH_CARRY_L5: alu_fn = ALU_ADD_WITH_CARRY;
      OP_ASR_F, OP_ASR_W: alu_fn = ALU_ASR1;
      OP_ASR_REG, OP_ASR_LIT: alu_fn = ALU_ASRN;
      OP_BIT_CLEAR_OP_F, OP_BIT_CLEAR_OP_W: alu_fn = ALU_BIT_CLEAR_OP;
      default: alu_fn = ALU_AND;
    endcase
  end

  always_comb begin
    pair   = MAC_PAIRS[0];
    acc_go = 1'b0;
    if (cmd.op == OP_MAC && cmd.dst[2:0] < NUM_PAIRS) begin
      pair   = MAC_PAIRS[cmd.dst[2:0]];
      acc_go = 1'b1;
    end
    ma = pair[7:4];
    mb = pair[3:0];
    if (cmd.op == OP_SQR) begin
      ma     = W_PFD + {2'b00, cmd.dst[1:0]};
      mb     = ma;
      acc_go = 1'b1;
    end
    prod    = $signed(w_reg[ma]) * $signed(w_reg[mb]);
    ext     = {{8{w_reg[cmd.src][15]}}, w_reg[cmd.src], 16'h0000};
    acc_add = {{8{prod[31]}}, prod};
    if (cmd.op == OP_ACC_ADD) begin
      acc_go  = 1'b1;
      acc_add = cmd.lit[3] ? (ext << (4'h0 - cmd.lit[3:0]))
                           : 40'($signed(ext) >>> cmd.lit[3:0]);
    end
    acc_res = acc_sum(cmd.acc_sel ? acc_b_reg : acc_a_reg, acc_add);
    if (w_reg[cmd.src] == 16'h0000) begin
      quo = DIV_Z_Q;
      rem = w_reg[cmd.base];
    end else begin
      quo = 16'($signed(w_reg[cmd.base]) / $signed(w_reg[cmd.src]));
      rem = 16'($signed(w_reg[cmd.base]) % $signed(w_reg[cmd.src]));
    end
  end

  function automatic logic [41:0] acc_sum(input logic [39:0] acc, input logic [39:0] add);
    logic [40:0] s;
    logic        sat;
    logic [39:0] r;
    s   = {acc[39], acc} + {add[39], add};
    sat = s[40] ^ s[39];
    r   = sat ? (s[40] ? ACC_MIN : ACC_MAX) : s[39:0];
    return {sat, !(&r[39:31] || !(|r[39:31])), r};
  endfunction

  dsa_alu u_alu (
    .fn        (alu_fn),
    .byte_mode (cmd.byte_mode),
    .a         (alu_a),
    .b         (alu_b),
    .cnt       (alu_cnt),
    .fin       (flags_reg),
    .res       (alu_r),
    .fout      (alu_fl)
  );

  dsa_agu u_agu_x (
    .mode   (cmd.lit[3:0]),
    .ptr_lo (w_reg[W_XLO]),
    .ptr_hi (w_reg[W_XHI]),
    .idx    (w_reg[W_IDX]),
    .pf     (xpf)
  );

  dsa_agu u_agu_y (
    .mode   (cmd.lit[7:4]),
    .ptr_lo (w_reg[W_YLO]),
    .ptr_hi (w_reg[W_YHI]),
    .idx    (w_reg[W_IDX]),
    .pf     (ypf)
  );

  // ****************************
  // Core state
  // ****************************
  always_comb begin
    w_next     = w_reg;
    mem_next   = mem_reg;
    acc_a_next = acc_a_reg;
    acc_b_next = acc_b_reg;
    flags_next = flags_reg;
    accf_next  = accf_reg;
    if (wr_reg && ok_reg) begin
      if (adr_reg == ADDR_STAT) begin
        flags_next = dsa_flags_t'(HWDATA[4:0]);
        accf_next  = dsa_accf_t'(HWDATA[STAT_ACCF+3:STAT_ACCF]);
      end
      if (adr_reg == ADDR_ACCA0) acc_a_next[31:0] = HWDATA;
      if (adr_reg == ADDR_ACCA1) acc_a_next[39:32] = HWDATA[7:0];
      if (adr_reg == ADDR_ACCB0) acc_b_next[31:0] = HWDATA;
      if (adr_reg == ADDR_ACCB1) acc_b_next[39:32] = HWDATA[7:0];
      if (w_hit) w_next[w_idx] = HWDATA[15:0];
      if (m_hit) mem_next[m_idx] = HWDATA[15:0];
    end
    if (exec && alu_go) begin
      flags_next = alu_fl;
      if (to_mem) begin
        mem_next[f_idx] = alu_r;
      end else begin
        w_next[dst_idx] = alu_r;
      end
    end
    if (exec && acc_go) begin
      if (cmd.acc_sel) begin
        acc_b_next   = acc_res[39:0];
        accf_next.ob = acc_res[40];
        accf_next.sb = accf_reg.sb | acc_res[41];
      end else begin
        acc_a_next   = acc_res[39:0];
        accf_next.oa = acc_res[40];
        accf_next.sa = accf_reg.sa | acc_res[41];
      end
    end
    if (exec && (cmd.op == OP_MAC || cmd.op == OP_SQR)) begin
      if (xpf.en) w_next[W_PFD + {2'b00, cmd.src[1:0]}] = mem_reg[xpf.addr[MW:1]];
      if (ypf.en) w_next[W_PFD + {2'b00, cmd.src[3:2]}] = mem_reg[ypf.addr[MW:1]];
      if (xpf.upd) w_next[xpf.hi ? W_XHI : W_XLO] = xpf.ptr;
      if (ypf.upd) w_next[ypf.hi ? W_YHI : W_YLO] = ypf.ptr;
    end
    if (exec && cmd.op == OP_DIV) begin
      w_next[W_IMPL] = quo;
      w_next[W_REM]  = rem;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < NUM_W; i++) begin
        w_reg[i] <= W_RST;
      end
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_reg[i] <= W_RST;
      end
      acc_a_reg <= ACC_RST;
      acc_b_reg <= ACC_RST;
      flags_reg <= '0;
      accf_reg  <= '0;
    end else begin
      w_reg     <= w_next;
      mem_reg   <= mem_next;
      acc_a_reg <= acc_a_next;
      acc_b_reg <= acc_b_next;
      flags_reg <= flags_next;
      accf_reg  <= accf_next;
    end
  end
endmodule

// ### sim/dsa_alu_core_properties.sv
// Purpose: bus timing and register image properties of the ALU slice
// Assumes: one slave, HREADY fed back from HREADYOUT
// Notes:   bound into the top module
`timescale 1ns/1ps
module dsa_core_props
  import dsa_pkg::*;
#(
  parameter int MEM_DEPTH = 64
)
(
  input logic        SYS_CLK,
  input logic        NRST,
  input logic        HSEL,
  input logic [31:0] HADDR,
  input logic [1:0]  HTRANS,
  input logic        HWRITE,
  input logic [2:0]  HSIZE,
  input logic [31:0] HWDATA,
  input logic        HREADY,
  input logic [31:0] HRDATA,
  input logic        HREADYOUT,
  input logic        HRESP
);
  // ****************************
  // Transfer decode
  // ****************************
  logic take_rd;
  logic take_wr;
  assign take_rd = HSEL && HREADY && HTRANS[1] && !HWRITE;
  assign take_wr = HSEL && HREADY && HTRANS[1] && HWRITE;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);
  sequence rd_done;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  // ****************************
  // Assertions
  // ****************************
  a_resp_okay: assert property (HRESP == 1'b0)
    else $error("error response seen");
  a_read_wait: assert property (take_rd |=> rd_done)
    else $error("read data phase not one wait state");
  a_write_nowait: assert property (take_wr |=> HREADYOUT)
    else $error("write or command stalled the bus");
  a_wait_single: assert property (!HREADYOUT |=> HREADYOUT)
    else $error("wait state longer than one cycle");
  a_rdata_hold: assert property (HREADYOUT && $past(HREADYOUT) |-> $stable(HRDATA))
    else $error("read data changed outside a read");
  a_stat_upper: assert property (
    take_rd && HADDR == {20'h0, ADDR_STAT} |=> rd_done ##0 HRDATA[31:12] == 20'h0)
    else $error("status read shows bits above the flags");
  a_default_work_reg_upper: assert property (
    take_rd && HADDR[31:6] == 26'h1 |=> rd_done ##0 HRDATA[31:16] == 16'h0)
    else $error("working register read wider than 16 bits");
  a_acc_hibyte: assert property (
    take_rd && (HADDR == {20'h0, ADDR_ACCA1} || HADDR == {20'h0, ADDR_ACCB1})
    |=> rd_done ##0 HRDATA[31:8] == 24'h0)
    else $error("accumulator top word wider than 8 bits");
endmodule

bind dsa_alu_core dsa_core_props #(.MEM_DEPTH(MEM_DEPTH)) props_u (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP)
);

// ### sim/dsa_host_model.sv
// Purpose: decoder side model issuing single word bus transfers
// Assumes: one slave, hready is the slave's ready
// Notes:   one idle cycle between transfers
`timescale 1ns/1ps
module dsa_host_model (
  input  logic        clk,
  input  logic        hready,
  input  logic [31:0] hrdata,
  output logic        hsel,
  output logic [31:0] haddr,
  output logic [1:0]  htrans,
  output logic        hwrite,
  output logic [2:0]  hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Address phase, then data phase, each held until ready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (!hready) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (!hready) @(posedge clk);
    q = hrdata;
  endtask
endmodule

// ### sim/test_dsa_alu_core.sv
// Purpose: self-checking bench for the operand ALU slice
// Assumes: host model drives the bus, bench model tracks W, memory, flags
// Notes:   random instruction stream then directed DSP cases
`timescale 1ns/1ps
`define CK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module test_dsa_alu_core
  import dsa_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q, c;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] w [16];
  logic [15:0] mem [64];
  logic [4:0]  st = 5'h0;
  int          num_errors = 0, num_checks = 0, seed = 35142, cyc = 0;
  dsa_op_t     ops [14] = '{OP_ADD_WITH_CARRY_F, OP_ADD_WITH_CARRY_L10, OP_ADD_WITH_CARRY_RR, OP_ADD_WITH_CARRY_L5, OP_AND_F,
    OP_AND_L10, OP_AND_RR, OP_AND_L5, OP_ASR_F, OP_ASR_W, OP_ASR_REG, OP_ASR_LIT,
    OP_BIT_CLEAR_OP_F, OP_BIT_CLEAR_OP_W};
  always #2.5 clk = ~clk;
  dsa_host_model host_u (
    .clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );
  dsa_alu_core #(.MEM_DEPTH(64)) dut_u (
    .SYS_CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp)
  );
  // ****************************
  // Bus helpers
  // ****************************
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q);
  endtask
  task automatic rdck(input logic [11:0] a, input logic [31:0] e);
    host_u.xfer(1'b0, a, 32'h0, q);
    `CK(q, e)
  endtask
  task automatic wset(input int n, input logic [15:0] v);
    w[n] = v;
    wr(ADDR_WBASE + 12'(4 * n), {16'h0, v});
  endtask
  function automatic logic [31:0] cmd(dsa_op_t op, int b, int s, int d, int l, bit ac);
    return {2'h0, ac, 2'h0, 10'(l), 4'(d), 4'(s), 4'(b), op};
  endfunction
  // ****************************
  // Reference model of one instruction
  // ****************************
  task automatic run(input logic [31:0] cw);
    dsa_op_t     op;
    logic        fo;
    logic [3:0]  b, s, d;
    logic [9:0]  l;
    logic [15:0] x, y;
    logic [16:0] r;
    logic [4:0]  h;
    logic [11:0] da;
    op = dsa_op_t'(cw[4:0]);
    b = cw[8:5];
    s = cw[12:9];
    d = cw[16:13];
    l = cw[26:17];
    fo = op inside {OP_ADD_WITH_CARRY_F, OP_AND_F, OP_ASR_F, OP_BIT_CLEAR_OP_F};
    x = fo ? mem[l[5:0]] : (op inside {OP_ADD_WITH_CARRY_L10, OP_AND_L10}) ? {6'h0, l}
      : (op inside {OP_ASR_W, OP_BIT_CLEAR_OP_W}) ? w[s] : w[b];
    y = fo ? w[0] : (op inside {OP_ADD_WITH_CARRY_L10, OP_AND_L10}) ? w[d]
      : (op inside {OP_ADD_WITH_CARRY_L5, OP_AND_L5, OP_ASR_LIT}) ? {11'h0, l[4:0]} : w[s];
    h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, st[0]};
    r = {1'b0, x} + {1'b0, y} + {16'h0, st[0]};
    case (op)
      OP_AND_F, OP_AND_L10, OP_AND_RR, OP_AND_L5: r = {1'b0, x & y};
      OP_ASR_F, OP_ASR_W: r = {x[0], 16'($signed(x) >>> 1)};
      OP_ASR_REG, OP_ASR_LIT: r = {1'b0, 16'($signed(x) >>> y[4:0])};
      OP_BIT_CLEAR_OP_F, OP_BIT_CLEAR_OP_W: r = {1'b0, x & ~(16'h1 << l[3:0])};
      default: ;
    endcase
    case (op)
      OP_ADD_WITH_CARRY_F, OP_ADD_WITH_CARRY_L10, OP_ADD_WITH_CARRY_RR, OP_ADD_WITH_CARRY_L5:
        st = {h[4], r[15], x[15] == y[15] && r[15] != x[15],
              st[1] && r[15:0] == 16'h0, r[16]};
      OP_ASR_F, OP_ASR_W: st = {st[4], r[15], 1'b0, r[15:0] == 16'h0, r[16]};
      OP_BIT_CLEAR_OP_F, OP_BIT_CLEAR_OP_W: ;
      default: st = {st[4], r[15], st[2], r[15:0] == 16'h0, st[0]};
    endcase
    if (fo && !(cw[28] && op != OP_BIT_CLEAR_OP_F))
      da = ADDR_MBASE + {4'h0, l[5:0], 2'h0};
    else if (fo)
      da = ADDR_WBASE;
    else if (op == OP_BIT_CLEAR_OP_W)
      da = ADDR_WBASE + {6'h0, s, 2'h0};
    else
      da = ADDR_WBASE + {6'h0, d, 2'h0};
    if (da >= ADDR_MBASE)
      mem[l[5:0]] = r[15:0];
    else
      w[da[5:2]] = r[15:0];
    wr(ADDR_CMD, cw);
    rdck(da, {16'h0, r[15:0]});
    rdck(ADDR_STAT, {27'h0, st});
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  // ****************************
  // Main sequence
  // ****************************
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rdck(ADDR_STAT, 32'h0);
    rdck(ADDR_ACCB1, 32'h0);
    rdck(12'hffc, 32'h0);
    for (int n = 0; n < 64; n++) begin
      mem[n] = 16'($random(seed));
      wr(ADDR_MBASE + 12'(4 * n), {16'h0, mem[n]});
    end
    for (int n = 0; n < 16; n++)
      wset(n, 16'($random(seed)));
    for (int n = 0; n < 16; n++)
      rdck(ADDR_WBASE + 12'(4 * n), {16'h0, w[n]});
    $display("test registers done");
    for (int i = 0; i < 300; i++) begin
      st = 5'($random(seed));
      wr(ADDR_STAT, {27'h0, st});
      c = $random(seed);
      c[4:0] = ops[$unsigned($random(seed)) % 14];
      c[27] = 1'b0;
      run(c);
    end
    $display("test random stream done");
    wset(4, 16'h0003);
    wset(5, 16'hfffe);
    wr(ADDR_CMD, cmd(OP_MAC, 0, 0, 0, 10'h077, 1'b0));
    rdck(ADDR_ACCA0, 32'hffff_fffa);
    rdck(ADDR_ACCA1, 32'h0000_00ff);
    wset(8, 16'h0010);
    wset(11, 16'h0020);
    wset(12, 16'h0004);
    wr(ADDR_CMD, cmd(OP_SQR, 0, 6, 1, 10'h0f1, 1'b1));
    rdck(ADDR_ACCB0, 32'h0000_0004);
    rdck(ADDR_ACCA0, 32'hffff_fffa);
    rdck(ADDR_WBASE + 12'h020, 32'h0000_0012);
    rdck(ADDR_WBASE + 12'h02c, 32'h0000_0020);
    rdck(ADDR_WBASE + 12'h018, {16'h0, mem[8]});
    rdck(ADDR_WBASE + 12'h014, {16'h0, mem[18]});
    $display("test multiply and prefetch done");
    wset(3, 16'h0001);
    wr(ADDR_CMD, cmd(OP_ACC_ADD, 0, 3, 0, 0, 1'b0));
    rdck(ADDR_ACCA0, 32'h0000_fffa);
    wset(3, 16'h7fff);
    wr(ADDR_CMD, cmd(OP_ACC_ADD, 0, 3, 0, 8, 1'b0));
    rdck(ADDR_ACCA0, 32'hff00_fffa);
    rdck(ADDR_ACCA1, 32'h0000_007f);
    rdck(ADDR_STAT, {20'h0, 4'h1, 3'h0, st});
    wr(ADDR_CMD, cmd(OP_ACC_ADD, 0, 3, 0, 8, 1'b0));
    rdck(ADDR_ACCA0, 32'hffff_ffff);
    rdck(ADDR_ACCA1, 32'h0000_007f);
    rdck(ADDR_STAT, {20'h0, 4'h5, 3'h0, st});
    wr(ADDR_CMD, cmd(OP_MAC, 0, 0, 6, 10'h0c7, 1'b0));
    rdck(ADDR_ACCA0, 32'hffff_ffff);
    rdck(ADDR_WBASE + 12'h02c, 32'h0000_001e);
    rdck(ADDR_WBASE + 12'h010, {16'h0, mem[16]});
    wset(2, 16'h0064);
    wset(3, 16'hfff9);
    wr(ADDR_CMD, cmd(OP_DIV, 2, 3, 0, 0, 1'b0));
    rdck(ADDR_WBASE, 32'h0000_fff2);
    rdck(ADDR_WBASE + 12'h004, 32'h0000_0002);
    wset(7, 16'h12f0);
    wr(ADDR_STAT, 32'h0);
    wr(ADDR_CMD, cmd(OP_ADD_WITH_CARRY_L10, 0, 0, 7, 10'h3a5, 1'b0) | 32'h0800_0000);
    rdck(ADDR_WBASE + 12'h01c, 32'h0000_1295);
    rdck(ADDR_STAT, 32'h0000_0009);
    $display("test accumulator and divide done");
    give_verdict();
  end
endmodule
